// *** gpb_pin_irq.sv ***
module gpb_pin_irq (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // Pin and trigger set-up
  input  wire logic pin_in,
  input  wire logic sense_level,
  input  wire logic both_edges,
  input  wire logic event_high,
  input  wire logic clr,
  // Results
  output logic      pin_sync,
  output logic      raw
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic prev;
    logic edge_flag;
  } gpb_pin_state_t;

  gpb_pin_state_t q;
  gpb_pin_state_t d;
  logic           rise;
  logic           fall;
  logic           hit;

  assign rise = q.s2 & ~q.prev;
  assign fall = ~q.s2 & q.prev;
  assign hit  = ~sense_level & (both_edges ? (rise | fall)
                                           : (event_high ? rise : fall));

  always_comb
  begin
    d           = q;
    d.s1        = pin_in;
    d.s2        = q.s1;
    d.prev      = q.s2;
    // Set wins over a clear arriving in the same cycle
    d.edge_flag = hit | (q.edge_flag & ~clr & ~sense_level);
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign pin_sync = q.s2;
  // Level mode follows the pin, no latch
  assign raw = sense_level ? (q.s2 == event_high) : q.edge_flag;

  property p_edge_hold;
    @(posedge clk_sys) disable iff (rst)
    (q.edge_flag && !clr && !sense_level) |=> q.edge_flag;
  endproperty
  a_edge_hold: assert property (p_edge_hold) else $error("edge flag lost");

  property p_edge_clr;
    @(posedge clk_sys) disable iff (rst)
    (q.edge_flag && clr && !hit) |=> !raw || sense_level;
  endproperty
  a_edge_clr: assert property (p_edge_clr) else $error("edge flag not cleared");

  property p_rise_only;
    @(posedge clk_sys) disable iff (rst)
    (!sense_level && !both_edges && event_high && rise) ##1 !sense_level |-> raw;
  endproperty
  a_rise_only: assert property (p_rise_only) else $error("rising edge missed");

endmodule

// *** gpb_gpio.sv ***
package gpb_pkg;
  localparam int          NUM_PORTS   = 8;
  localparam int          PIN_W       = 8;
  localparam int          MASK_LSB    = 2;
  localparam int          MASK_MSB    = 9;
  localparam int          DATA_LOCS   = 256;
  localparam int          PORT_B      = 1;
  localparam int          PORT_C      = 2;
  localparam int          CONV_PIN    = 4;
  localparam logic [7:0]  DBG_MASK_B  = 8'h80;
  localparam logic [7:0]  DBG_MASK_C  = 8'h0f;
  localparam logic [7:0]  RST_ZERO    = 8'h00;
  localparam logic [7:0]  RST_DR2R    = 8'hff;
  localparam logic [7:0]  ALL_PINS    = 8'hff;
  // Unlock key value is arbitrary
  localparam logic [31:0] LOCK_KEY    = 32'h1ace_b00c;
  // Identification values are arbitrary
  localparam logic [7:0][7:0] PERIPH_ID = 64'h0011_2233_4455_6677;
  localparam logic [3:0][7:0] CELL_ID   = 32'h0a1b_2c3d;

  typedef enum logic [4:0] {
    SEL_DIR   = 5'h00, SEL_IS    = 5'h01, SEL_IBE   = 5'h02, SEL_IEV  = 5'h03,
    SEL_IM    = 5'h04, SEL_RIS   = 5'h05, SEL_MIS   = 5'h06, SEL_ICR  = 5'h07,
    SEL_AFSEL = 5'h08, SEL_DR2R  = 5'h09, SEL_DR4R  = 5'h0a, SEL_DR8R = 5'h0b,
    SEL_ODR   = 5'h0c, SEL_PUR   = 5'h0d, SEL_PDR   = 5'h0e, SEL_SLR  = 5'h0f,
    SEL_DEN   = 5'h10, SEL_LOCK  = 5'h11, SEL_CR    = 5'h12, SEL_PID  = 5'h13,
    SEL_CID   = 5'h14
  } gpb_cfg_sel_t;
endpackage

////////////////////////////////////////////////////////////////////////////////

module gpb_port #(
  parameter logic [7:0] DBG_MASK = 8'h00,
  parameter bit         TRIG_EN  = 1'b0
) (
  // Clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 rst,
  // Masked data access
  input  wire logic                 dat_wr,
  input  wire logic                 dat_rd,
  input  wire logic [7:0]           dat_addr,
  input  wire logic [7:0]           dat_wdata,
  output logic      [7:0]           dat_rdata,
  // Configuration access
  input  wire logic                 cfg_wr,
  input  wire logic                 cfg_rd,
  input  wire gpb_pkg::gpb_cfg_sel_t cfg_sel,
  input  wire logic [2:0]           cfg_id_idx,
  input  wire logic [31:0]          cfg_wdata,
  output logic      [31:0]          cfg_rdata,
  // Pins
  input  wire logic [7:0]           pin_in,
  output logic      [7:0]           pin_out,
  output logic      [7:0]           pin_oe_n,
  // Peripheral hand-off
  input  wire logic [7:0]           alt_out,
  input  wire logic [7:0]           alt_oe,
  output logic      [7:0]           alt_in,
  // Pad controls
  output logic      [7:0]           pad_den,
  output logic      [7:0]           pad_pur,
  output logic      [7:0]           pad_pdr,
  output logic      [7:0]           pad_odr,
  output logic      [7:0]           pad_slr,
  output logic      [7:0]           pad_dr2,
  output logic      [7:0]           pad_dr4,
  output logic      [7:0]           pad_dr8,
  // Events
  output logic                      irq,
  output logic                      conv_trig
);

  typedef struct packed {
    logic [7:0]  dir;
    logic [7:0]  is;
    logic [7:0]  ibe;
    logic [7:0]  iev;
    logic [7:0]  im;
    logic [7:0]  afsel;
    logic [7:0]  odr;
    logic [7:0]  pur;
    logic [7:0]  pdr;
    logic [7:0]  den;
    logic [7:0]  slr;
    logic [7:0]  dr2;
    logic [7:0]  dr4;
    logic [7:0]  dr8;
    logic [7:0]  cr;
    logic [7:0]  data;
    logic        locked;
    logic [7:0]  dat_rdata;
    logic [31:0] cfg_rdata;
    logic        trig;
    logic        mis_prev;
  } gpb_port_state_t;

  localparam gpb_port_state_t RST_STATE = '{
    dir: gpb_pkg::RST_ZERO, is: gpb_pkg::RST_ZERO, ibe: gpb_pkg::RST_ZERO,
    iev: gpb_pkg::RST_ZERO, im: gpb_pkg::RST_ZERO,
    afsel: DBG_MASK, odr: gpb_pkg::RST_ZERO, pur: DBG_MASK,
    pdr: gpb_pkg::RST_ZERO, den: DBG_MASK, slr: gpb_pkg::RST_ZERO,
    dr2: gpb_pkg::RST_DR2R, dr4: gpb_pkg::RST_ZERO, dr8: gpb_pkg::RST_ZERO,
    cr: ~DBG_MASK, data: gpb_pkg::RST_ZERO, locked: 1'b1,
    dat_rdata: 8'h00, cfg_rdata: 32'h0000_0000, trig: 1'b0, mis_prev: 1'b0
  };

  gpb_port_state_t q;
  gpb_port_state_t d;
  logic [7:0]      sync;
  logic [7:0]      ris;
  logic [7:0]      mis;
  logic [7:0]      clr;
  logic [7:0]      drv_val;
  logic [7:0]      drv_en;
  logic            wr_sel;
  logic [7:0]      commit_ok;

  ////////////////////////////////////////////////////////////////////////////
  // Per-pin synchroniser and trigger detection

  assign wr_sel = cfg_wr && (cfg_sel == gpb_pkg::SEL_ICR);
  // Protected pins need both the unlock and their commit bit
  assign commit_ok = q.cr & ~(DBG_MASK & {8{q.locked}});
  assign clr    = wr_sel ? cfg_wdata[7:0] : 8'h00;

  for (genvar i = 0; i < gpb_pkg::PIN_W; i++)
  begin : g_pin
    gpb_pin_irq u_pin (
      .clk_sys     (clk_sys),
      .rst         (rst),
      .pin_in      (pin_in[i] & q.den[i]),
      .sense_level (q.is[i]),
      .both_edges  (q.ibe[i]),
      .event_high  (q.iev[i]),
      .clr         (clr[i]),
      .pin_sync    (sync[i]),
      .raw         (ris[i])
    );
  end

  assign mis = ris & q.im;
  assign irq = |mis;

  ////////////////////////////////////////////////////////////////////////////
  // Register updates

  always_comb
  begin
    d           = q;
    d.trig      = 1'b0;
    d.mis_prev  = mis[gpb_pkg::CONV_PIN];
    // Input pins keep sampling the pad
    d.data = (q.data & q.dir) | (sync & ~q.dir);
    if (dat_wr)
    begin
      d.data = (d.data & ~(dat_addr & q.dir))
             | (dat_wdata & dat_addr & q.dir);
    end
    if (dat_rd)
    begin
      d.dat_rdata = q.data & dat_addr;
    end
    if (TRIG_EN && mis[gpb_pkg::CONV_PIN] && !q.mis_prev)
    begin
      d.trig = 1'b1;
    end
    if (cfg_wr)
    begin
      if (cfg_sel == gpb_pkg::SEL_DIR)
      begin
        d.dir = cfg_wdata[7:0];
      end
      else if (cfg_sel == gpb_pkg::SEL_IS)
      begin
        d.is = cfg_wdata[7:0];
      end
      else if (cfg_sel == gpb_pkg::SEL_IBE)
      begin
        d.ibe = cfg_wdata[7:0];
      end
      else if (cfg_sel == gpb_pkg::SEL_IEV)
      begin
        d.iev = cfg_wdata[7:0];
      end
      else if (cfg_sel == gpb_pkg::SEL_IM)
      begin
        d.im = cfg_wdata[7:0];
      end
      else if (cfg_sel == gpb_pkg::SEL_AFSEL)
      begin
        // Uncommitted bits keep their value
        d.afsel = (q.afsel & ~commit_ok) | (cfg_wdata[7:0] & commit_ok);
      end
      else if (cfg_sel == gpb_pkg::SEL_DR2R)
      begin
        d.dr2 = cfg_wdata[7:0];
        d.dr4 = q.dr4 & ~cfg_wdata[7:0];
        d.dr8 = q.dr8 & ~cfg_wdata[7:0];
      end
      else if (cfg_sel == gpb_pkg::SEL_DR4R)
      begin
        d.dr4 = cfg_wdata[7:0];
        d.dr2 = q.dr2 & ~cfg_wdata[7:0];
        d.dr8 = q.dr8 & ~cfg_wdata[7:0];
      end
      else if (cfg_sel == gpb_pkg::SEL_DR8R)
      begin
        d.dr8 = cfg_wdata[7:0];
        d.dr2 = q.dr2 & ~cfg_wdata[7:0];
        d.dr4 = q.dr4 & ~cfg_wdata[7:0];
      end
      else if (cfg_sel == gpb_pkg::SEL_ODR)
      begin
        d.odr = cfg_wdata[7:0];
      end
      else if (cfg_sel == gpb_pkg::SEL_PUR)
      begin
        d.pur = cfg_wdata[7:0];
      end
      else if (cfg_sel == gpb_pkg::SEL_PDR)
      begin
        d.pdr = cfg_wdata[7:0];
      end
      else if (cfg_sel == gpb_pkg::SEL_SLR)
      begin
        d.slr = cfg_wdata[7:0];
      end
      else if (cfg_sel == gpb_pkg::SEL_DEN)
      begin
        d.den = cfg_wdata[7:0];
      end
      else if (cfg_sel == gpb_pkg::SEL_LOCK)
      begin
        d.locked = (cfg_wdata != gpb_pkg::LOCK_KEY);
      end
      else if (cfg_sel == gpb_pkg::SEL_CR && !q.locked)
      begin
        // Only debug pins are protected; the rest stay committable
        d.cr = (cfg_wdata[7:0] & DBG_MASK) | ~DBG_MASK;
      end
    end
    if (cfg_rd)
    begin
      d.cfg_rdata = 32'h0000_0000;
      if (cfg_sel == gpb_pkg::SEL_DIR)
      begin
        d.cfg_rdata[7:0] = q.dir;
      end
      else if (cfg_sel == gpb_pkg::SEL_IS)
      begin
        d.cfg_rdata[7:0] = q.is;
      end
      else if (cfg_sel == gpb_pkg::SEL_IBE)
      begin
        d.cfg_rdata[7:0] = q.ibe;
      end
      else if (cfg_sel == gpb_pkg::SEL_IEV)
      begin
        d.cfg_rdata[7:0] = q.iev;
      end
      else if (cfg_sel == gpb_pkg::SEL_IM)
      begin
        d.cfg_rdata[7:0] = q.im;
      end
      else if (cfg_sel == gpb_pkg::SEL_RIS)
      begin
        d.cfg_rdata[7:0] = ris;
      end
      else if (cfg_sel == gpb_pkg::SEL_MIS)
      begin
        d.cfg_rdata[7:0] = mis;
      end
      else if (cfg_sel == gpb_pkg::SEL_AFSEL)
      begin
        d.cfg_rdata[7:0] = q.afsel;
      end
      else if (cfg_sel == gpb_pkg::SEL_DR2R)
      begin
        d.cfg_rdata[7:0] = q.dr2;
      end
      else if (cfg_sel == gpb_pkg::SEL_DR4R)
      begin
        d.cfg_rdata[7:0] = q.dr4;
      end
      else if (cfg_sel == gpb_pkg::SEL_DR8R)
      begin
        d.cfg_rdata[7:0] = q.dr8;
      end
      else if (cfg_sel == gpb_pkg::SEL_ODR)
      begin
        d.cfg_rdata[7:0] = q.odr;
      end
      else if (cfg_sel == gpb_pkg::SEL_PUR)
      begin
        d.cfg_rdata[7:0] = q.pur;
      end
      else if (cfg_sel == gpb_pkg::SEL_PDR)
      begin
        d.cfg_rdata[7:0] = q.pdr;
      end
      else if (cfg_sel == gpb_pkg::SEL_SLR)
      begin
        d.cfg_rdata[7:0] = q.slr;
      end
      else if (cfg_sel == gpb_pkg::SEL_DEN)
      begin
        d.cfg_rdata[7:0] = q.den;
      end
      else if (cfg_sel == gpb_pkg::SEL_LOCK)
      begin
        d.cfg_rdata[0] = q.locked;
      end
      else if (cfg_sel == gpb_pkg::SEL_CR)
      begin
        d.cfg_rdata[7:0] = q.cr;
      end
      else if (cfg_sel == gpb_pkg::SEL_PID)
      begin
        d.cfg_rdata[7:0] = gpb_pkg::PERIPH_ID[cfg_id_idx];
      end
      else if (cfg_sel == gpb_pkg::SEL_CID)
      begin
        d.cfg_rdata[7:0] = gpb_pkg::CELL_ID[cfg_id_idx[1:0]];
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      q <= RST_STATE;
    end
    else
    begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pad drive

  assign drv_val  = (q.afsel & alt_out) | (~q.afsel & q.data);
  assign drv_en   = ((q.afsel & alt_oe) | (~q.afsel & q.dir)) & q.den;
  // Open drain only pulls low
  assign pin_out  = drv_val & ~q.odr;
  assign pin_oe_n = ~(drv_en & (~q.odr | ~drv_val));
  assign alt_in   = sync;
  assign pad_den  = q.den;
  assign pad_pur  = q.pur;
  assign pad_pdr  = q.pdr;
  assign pad_odr  = q.odr;
  assign pad_slr  = q.slr;
  assign pad_dr2  = q.dr2;
  assign pad_dr4  = q.dr4;
  assign pad_dr8  = q.dr8;
  assign dat_rdata = q.dat_rdata;
  assign cfg_rdata = q.cfg_rdata;
  assign conv_trig = q.trig;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_wr_keep;
    dat_wr |=> ((q.data ^ $past(q.data)) & $past(~dat_addr & q.dir)) == 8'h00;
  endproperty
  a_wr_keep: assert property (p_wr_keep) else $error("unmasked bit changed");

  property p_wr_set;
    dat_wr |=> ((q.data ^ $past(dat_wdata)) & $past(dat_addr & q.dir)) == 8'h00;
  endproperty
  a_wr_set: assert property (p_wr_set) else $error("masked bit not written");

  property p_rd_mask;
    dat_rd |=> (dat_rdata & ~$past(dat_addr)) == 8'h00
               && (dat_rdata & $past(dat_addr)) == ($past(q.data) & $past(dat_addr));
  endproperty
  a_rd_mask: assert property (p_rd_mask) else $error("masked read wrong");

  property p_input;
    ##1 $stable(q.dir) |-> (q.data & ~q.dir) == ($past(sync) & ~q.dir);
  endproperty
  a_input: assert property (p_input) else $error("input not sampled");

  property p_drive;
    ##1 $stable(q.data) |-> ((~q.afsel & q.dir & q.den & ~q.odr)
                            & (pin_oe_n | (pin_out ^ $past(q.data)))) == 8'h00;
  endproperty
  a_drive: assert property (p_drive) else $error("output not driven");

  property p_locked_af;
    (cfg_wr && cfg_sel == gpb_pkg::SEL_AFSEL && q.locked)
      |=> (q.afsel & DBG_MASK) == ($past(q.afsel) & DBG_MASK);
  endproperty
  a_locked_af: assert property (p_locked_af) else $error("protected bit changed");

  property p_trig;
    (TRIG_EN && $rose(mis[gpb_pkg::CONV_PIN])) |=> conv_trig ##1 !conv_trig;
  endproperty
  a_trig: assert property (p_trig) else $error("converter trigger missing");

  property p_mask_off;
    (cfg_wr && cfg_sel == gpb_pkg::SEL_IM && cfg_wdata[7:0] == 8'h00) |=> !irq;
  endproperty
  a_mask_off: assert property (p_mask_off) else $error("masked irq seen");

  property p_mis_rd;
    (cfg_rd && cfg_sel == gpb_pkg::SEL_MIS) |=> cfg_rdata[7:0] == $past(ris & q.im);
  endproperty
  a_mis_rd: assert property (p_mis_rd) else $error("masked status wrong");

  c_irq:   cover property ($rose(irq));
  c_trig:  cover property (conv_trig);
  c_wr:    cover property (dat_wr && dat_addr != 8'hff);
  c_af_ok: cover property (!q.locked && cfg_wr && cfg_sel == gpb_pkg::SEL_AFSEL);

endmodule

////////////////////////////////////////////////////////////////////////////////

module gpb_gpio (
  // Clock and reset
  input  wire logic                                    clk_sys,
  input  wire logic                                    rst,
  // Masked data access, one set per port
  input  wire logic [gpb_pkg::NUM_PORTS-1:0]           dat_wr,
  input  wire logic [gpb_pkg::NUM_PORTS-1:0]           dat_rd,
  input  wire logic [gpb_pkg::NUM_PORTS-1:0][7:0]      dat_addr,
  input  wire logic [gpb_pkg::NUM_PORTS-1:0][7:0]      dat_wdata,
  output logic      [gpb_pkg::NUM_PORTS-1:0][7:0]      dat_rdata,
  // Configuration access
  input  wire logic [gpb_pkg::NUM_PORTS-1:0]           cfg_wr,
  input  wire logic [gpb_pkg::NUM_PORTS-1:0]           cfg_rd,
  input  wire gpb_pkg::gpb_cfg_sel_t                   cfg_sel [gpb_pkg::NUM_PORTS],
  input  wire logic [gpb_pkg::NUM_PORTS-1:0][2:0]      cfg_id_idx,
  input  wire logic [gpb_pkg::NUM_PORTS-1:0][31:0]     cfg_wdata,
  output logic      [gpb_pkg::NUM_PORTS-1:0][31:0]     cfg_rdata,
  // Pins
  input  wire logic [gpb_pkg::NUM_PORTS-1:0][7:0]      pin_in,
  output logic      [gpb_pkg::NUM_PORTS-1:0][7:0]      pin_out,
  output logic      [gpb_pkg::NUM_PORTS-1:0][7:0]      pin_oe_n,
  // Peripheral hand-off
  input  wire logic [gpb_pkg::NUM_PORTS-1:0][7:0]      alt_out,
  input  wire logic [gpb_pkg::NUM_PORTS-1:0][7:0]      alt_oe,
  output logic      [gpb_pkg::NUM_PORTS-1:0][7:0]      alt_in,
  // Pad controls
  output logic      [gpb_pkg::NUM_PORTS-1:0][7:0]      pad_den,
  output logic      [gpb_pkg::NUM_PORTS-1:0][7:0]      pad_pur,
  output logic      [gpb_pkg::NUM_PORTS-1:0][7:0]      pad_pdr,
  output logic      [gpb_pkg::NUM_PORTS-1:0][7:0]      pad_odr,
  output logic      [gpb_pkg::NUM_PORTS-1:0][7:0]      pad_slr,
  output logic      [gpb_pkg::NUM_PORTS-1:0][7:0]      pad_dr2,
  output logic      [gpb_pkg::NUM_PORTS-1:0][7:0]      pad_dr4,
  output logic      [gpb_pkg::NUM_PORTS-1:0][7:0]      pad_dr8,
  // Events
  output logic      [gpb_pkg::NUM_PORTS-1:0]           irq,
  output logic                                         conv_trig
);

  logic [gpb_pkg::NUM_PORTS-1:0] trig;

  for (genvar p = 0; p < gpb_pkg::NUM_PORTS; p++)
  begin : g_port
    localparam logic [7:0] DBG = (p == gpb_pkg::PORT_B) ? gpb_pkg::DBG_MASK_B
                               : (p == gpb_pkg::PORT_C) ? gpb_pkg::DBG_MASK_C
                               : gpb_pkg::RST_ZERO;
    gpb_port #(
      .DBG_MASK (DBG),
      .TRIG_EN  (p == gpb_pkg::PORT_B)
    ) u_port (
      .clk_sys   (clk_sys),
      .rst       (rst),
      .dat_wr    (dat_wr[p]),
      .dat_rd    (dat_rd[p]),
      .dat_addr  (dat_addr[p]),
      .dat_wdata (dat_wdata[p]),
      .dat_rdata (dat_rdata[p]),
      .cfg_wr    (cfg_wr[p]),
      .cfg_rd    (cfg_rd[p]),
      .cfg_sel   (cfg_sel[p]),
      .cfg_id_idx(cfg_id_idx[p]),
      .cfg_wdata (cfg_wdata[p]),
      .cfg_rdata (cfg_rdata[p]),
      .pin_in    (pin_in[p]),
      .pin_out   (pin_out[p]),
      .pin_oe_n  (pin_oe_n[p]),
      .alt_out   (alt_out[p]),
      .alt_oe    (alt_oe[p]),
      .alt_in    (alt_in[p]),
      .pad_den   (pad_den[p]),
      .pad_pur   (pad_pur[p]),
      .pad_pdr   (pad_pdr[p]),
      .pad_odr   (pad_odr[p]),
      .pad_slr   (pad_slr[p]),
      .pad_dr2   (pad_dr2[p]),
      .pad_dr4   (pad_dr4[p]),
      .pad_dr8   (pad_dr8[p]),
      .irq       (irq[p]),
      .conv_trig (trig[p])
    );
  end

  assign conv_trig = |trig;

endmodule

// *** gpb_pin_model.sv ***
module gpb_pin_model (
  // Clock
  input  wire logic            clk_sys,
  // Pad side of the block
  input  wire logic [7:0][7:0] pin_out,
  input  wire logic [7:0][7:0] pin_oe_n,
  input  wire logic [7:0][7:0] pad_pur,
  input  wire logic [7:0][7:0] pad_pdr,
  // External sources
  input  wire logic [7:0][7:0] ext_val,
  input  wire logic [7:0][7:0] ext_en,
  // Resolved pad level
  output logic      [7:0][7:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic tog = 1'b0;
  always @(posedge clk_sys)
    tog <= ~tog;
  // Floating pins wander so a stale value never passes
  always_comb
  begin
    for (int p = 0; p < 8; p++)
    begin
      for (int b = 0; b < 8; b++)
      begin
        if (!pin_oe_n[p][b])
          pin_in[p][b] = pin_out[p][b];
        else if (ext_en[p][b])
          pin_in[p][b] = ext_val[p][b];
        else if (pad_pur[p][b] || pad_pdr[p][b])
          pin_in[p][b] = pad_pur[p][b];
        else
          pin_in[p][b] = tog ^ b[0];
      end
    end
  end
endmodule

// *** gpb_gpio_tb.sv ***
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin fails++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module gpb_gpio_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int NP = gpb_pkg::NUM_PORTS;
  logic                  clk_sys = 1'b0;
  logic                  rst = 1'b1;
  logic [NP-1:0]         dat_wr = '0, dat_rd = '0, cfg_wr = '0, cfg_rd = '0, irq;
  logic [NP-1:0][7:0]    dat_addr = '0, dat_wdata = '0, dat_rdata, pin_in, pin_out, pin_oe_n;
  logic [NP-1:0][7:0]    alt_out = '0, alt_oe = '0, pad_den, pad_pur, pad_pdr;
  logic [NP-1:0][7:0]    ext_val = '0, ext_en = '0;
  logic [NP-1:0][2:0]    cfg_id_idx = '0;
  logic [NP-1:0][31:0]   cfg_wdata = '0, cfg_rdata;
  gpb_pkg::gpb_cfg_sel_t cfg_sel [NP];
  logic                  conv_trig;
  int                    fails = 0, comparisons = 0, cycles = 0;
  always #50 clk_sys = ~clk_sys;
  initial
    foreach (cfg_sel[i]) cfg_sel[i] = gpb_pkg::SEL_DIR;
  gpb_gpio gpb_gpio_inst (.clk_sys, .rst, .dat_wr, .dat_rd, .dat_addr, .dat_wdata,
    .dat_rdata, .cfg_wr, .cfg_rd, .cfg_sel, .cfg_id_idx, .cfg_wdata, .cfg_rdata, .pin_in,
    .pin_out, .pin_oe_n, .alt_out, .alt_oe, .alt_in(), .pad_den, .pad_pur, .pad_pdr,
    .pad_odr(), .pad_slr(), .pad_dr2(), .pad_dr4(), .pad_dr8(), .irq, .conv_trig);
  gpb_pin_model gpb_pin_model_inst (.clk_sys, .pin_out, .pin_oe_n, .pad_pur, .pad_pdr,
    .ext_val, .ext_en, .pin_in);
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fails++;
      report_and_stop();
    end
  end
  task automatic cfg_acc(int p, bit wr, gpb_pkg::gpb_cfg_sel_t s, logic [31:0] d);
    @(posedge clk_sys);
    cfg_wr[p] <= wr;
    cfg_rd[p] <= !wr;
    cfg_sel[p] <= s;
    cfg_wdata[p] <= d;
    @(posedge clk_sys);
    cfg_wr[p] <= 1'b0;
    cfg_rd[p] <= 1'b0;
    #1;
    if (!wr) `CHK(s.name(), d, cfg_rdata[p])
  endtask
  task automatic dat_acc(int p, bit wr, logic [7:0] a, logic [7:0] d);
    @(posedge clk_sys);
    dat_wr[p] <= wr;
    dat_rd[p] <= !wr;
    dat_addr[p] <= a;
    dat_wdata[p] <= d;
    @(posedge clk_sys);
    dat_wr[p] <= 1'b0;
    dat_rd[p] <= 1'b0;
    #1;
    if (!wr) `CHK("data", d, dat_rdata[p])
  endtask
  task automatic pin_set(logic [7:0] v, int n);
    @(posedge clk_sys);
    ext_val[3] <= v;
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  initial
  begin
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    #1;
    `CHK("den_a", 8'h00, pad_den[0])
    `CHK("pdr_b", 8'h00, pad_pdr[1])
    `CHK("oe_a", 8'hff, pin_oe_n[0])
    `CHK("den_b", 8'h80, pad_den[1])
    `CHK("pur_c", 8'h0f, pad_pur[2])
    cfg_acc(1, 0, gpb_pkg::SEL_AFSEL, 32'h80);
    $display("test reset done");
    cfg_acc(0, 1, gpb_pkg::SEL_DIR, 32'hff);
    cfg_acc(0, 1, gpb_pkg::SEL_DEN, 32'hff);
    dat_acc(0, 1, 8'h26, 8'heb);
    `CHK("pin_out", 8'h22, pin_out[0])
    `CHK("oe_out", 8'h00, pin_oe_n[0])
    `CHK("oe_h", 8'hff, pin_oe_n[7])
    dat_acc(0, 1, 8'hff, 8'h5a);
    dat_acc(0, 0, 8'h31, 8'h10);
    $display("test data done");
    // Source holds each level steady until seen
    ext_en[3] <= 8'hff;
    ext_val[3] <= 8'ha4;
    cfg_acc(3, 1, gpb_pkg::SEL_DEN, 32'hff);
    pin_set(8'ha4, 3);
    dat_acc(3, 0, 8'hff, 8'ha4);
    dat_acc(3, 0, 8'h0f, 8'h04);
    // Trigger set up before unmasking
    cfg_acc(3, 1, gpb_pkg::SEL_IEV, 32'h01);
    cfg_acc(3, 1, gpb_pkg::SEL_IM, 32'h01);
    pin_set(8'ha5, 5);
    `CHK("irq", 1'b1, irq[3])
    cfg_acc(3, 0, gpb_pkg::SEL_MIS, 32'h01);
    pin_set(8'ha4, 5);
    `CHK("irq_held", 1'b1, irq[3])
    cfg_acc(3, 1, gpb_pkg::SEL_ICR, 32'h01);
    pin_set(8'ha4, 2);
    `CHK("irq_clr", 1'b0, irq[3])
    cfg_acc(3, 1, gpb_pkg::SEL_IM, 32'h00);
    pin_set(8'ha5, 5);
    `CHK("irq_mask", 1'b0, irq[3])
    cfg_acc(3, 0, gpb_pkg::SEL_RIS, 32'h01);
    cfg_acc(3, 0, gpb_pkg::SEL_MIS, 32'h00);
    cfg_acc(3, 1, gpb_pkg::SEL_IS, 32'h01);
    cfg_acc(3, 0, gpb_pkg::SEL_RIS, 32'h01);
    pin_set(8'ha4, 5);
    cfg_acc(3, 0, gpb_pkg::SEL_RIS, 32'h00);
    ext_en[1] <= 8'h10;
    cfg_acc(1, 1, gpb_pkg::SEL_DEN, 32'h90);
    cfg_acc(1, 1, gpb_pkg::SEL_IEV, 32'h10);
    cfg_acc(1, 1, gpb_pkg::SEL_IM, 32'h10);
    @(posedge clk_sys);
    ext_val[1] <= 8'h10;
    repeat (4) @(posedge clk_sys);
    #1;
    `CHK("conv_trig", 1'b1, conv_trig)
    @(posedge clk_sys);
    #1;
    `CHK("conv_end", 1'b0, conv_trig)
    `CHK("irq_b", 1'b1, irq[1])
    $display("test interrupt done");
    alt_oe[1] <= 8'h80;
    alt_out[1] <= 8'h80;
    @(posedge clk_sys);
    #1;
    `CHK("alt_oe", 1'b0, pin_oe_n[1][7])
    `CHK("alt_out", 1'b1, pin_out[1][7])
    $display("test alternate done");
    cfg_acc(2, 1, gpb_pkg::SEL_AFSEL, 32'h00);
    cfg_acc(2, 0, gpb_pkg::SEL_AFSEL, 32'h0f);
    cfg_acc(2, 1, gpb_pkg::SEL_LOCK, gpb_pkg::LOCK_KEY);
    cfg_acc(2, 1, gpb_pkg::SEL_CR, 32'hff);
    cfg_acc(2, 1, gpb_pkg::SEL_AFSEL, 32'h00);
    cfg_acc(2, 0, gpb_pkg::SEL_AFSEL, 32'h00);
    cfg_acc(2, 1, gpb_pkg::SEL_LOCK, 32'h0);
    cfg_acc(2, 0, gpb_pkg::SEL_LOCK, 32'h1);
    cfg_acc(2, 1, gpb_pkg::SEL_AFSEL, 32'h0f);
    cfg_acc(2, 0, gpb_pkg::SEL_AFSEL, 32'h00);
    cfg_acc(2, 1, gpb_pkg::SEL_PID, 32'h00);
    cfg_acc(2, 0, gpb_pkg::SEL_PID, {24'h0, gpb_pkg::PERIPH_ID[0]});
    $display("test commit done");
    report_and_stop();
  end
endmodule
